// File: hw/bpt_pkg.sv
package bpt_pkg;
    // ****************************************
    // data memory map
    // ****************************************
    localparam logic [7:0] BPT_FIRST_DATA_ADDR = 8'h12;
    localparam logic [7:0] BPT_FIRST_DIR_ADDR = 8'h13;
    localparam logic [7:0] BPT_SECOND_DATA_ADDR = 8'h14;
    localparam logic [7:0] BPT_SECOND_DIR_ADDR = 8'h15;
    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int BPT_FIRST_W = 8;
    localparam int BPT_SECOND_W = 4;
    localparam logic [7:0] BPT_DIR_RESET = 8'hff;
    localparam logic [7:0] BPT_DATA_RESET = 8'h00;
    // ****************************************
    // shared pin positions on the first port
    // ****************************************
    localparam int BPT_TONE_BIT = 0;
    localparam int BPT_TONE_N_BIT = 1;
    localparam int BPT_CNT0_BIT = 4;
    localparam int BPT_CNT1_BIT = 5;
    localparam int BPT_EXTINT_BIT = 6;
    // ****************************************
    // memory access kinds
    // ****************************************
    typedef enum logic [1:0] {
        BPT_OP_NONE,
        BPT_OP_READ,
        BPT_OP_WRITE
    } bpt_op_t;
endpackage : bpt_pkg

// File: hw/bpt_port.sv
// Functional notes
// RULE1 - twelve lines, data at 12h and 14h
// RULE2 - inputs unlatched, pad sampled on read
// RULE3 - output latch holds until rewritten
// RULE4 - per-line direction bits at 13h, 15h
// RULE5 - direction one: input, reads pad level
// RULE6 - direction zero: read returns output latch
// RULE7 - outputs are push-pull only
// RULE8 - after reset every line is input
// RULE9 - bit ops read whole port, write back
// RULE10 - every first-port line can wake device
// RULE11 - per-line pull-high option, else floating
// RULE12 - lines 0,1,4,5,6 share tone/counters/interrupt
// RULE13 - tone lines as inputs stay inputs
// RULE14 - line 0 data gates tone on line 0
// RULE15 - line 1 inverted tone only when both outputs
// RULE16 - directions reset ones, options static inputs
`timescale 1ns/100ps
module bpt_port
    import bpt_pkg::*;
(
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [7:0] mem_addr_in,
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [7:0] mem_wdata_in,
    output logic [7:0] mem_rdata_out,
    output logic mem_hit_out,
    input wire logic [BPT_FIRST_W-1:0] first_port_lines_in,
    output logic [BPT_FIRST_W-1:0] first_port_lines_out,
    output logic [BPT_FIRST_W-1:0] first_port_lines_oe_out,
    input wire logic [BPT_SECOND_W-1:0] second_port_lines_in,
    output logic [BPT_SECOND_W-1:0] second_port_lines_out,
    output logic [BPT_SECOND_W-1:0] second_port_lines_oe_out,
    input wire logic [BPT_FIRST_W-1:0] first_pull_high_opt_in,
    input wire logic [BPT_SECOND_W-1:0] second_pull_high_opt_in,
    output logic [BPT_FIRST_W-1:0] first_pull_high_en_out,
    output logic [BPT_SECOND_W-1:0] second_pull_high_en_out,
    input wire logic [BPT_FIRST_W-1:0] wake_opt_in,
    input wire logic halted_in,
    output logic wake_out,
    input wire logic tone_opt_in,
    input wire logic tone_in,
    output logic counter0_ext_input_out,
    output logic counter1_ext_input_out,
    output logic ext_int_n_out
);
    // ****************************************
    // pad synchronisers
    // ****************************************
    logic [BPT_FIRST_W-1:0] first_meta_r;
    logic [BPT_FIRST_W-1:0] first_sync_r;
    logic [BPT_SECOND_W-1:0] second_meta_r;
    logic [BPT_SECOND_W-1:0] second_sync_r;
    logic [BPT_FIRST_W-1:0] first_data_r;
    logic [BPT_FIRST_W-1:0] first_dir_r;
    logic [BPT_SECOND_W-1:0] second_data_r;
    logic [BPT_SECOND_W-1:0] second_dir_r;
    logic [BPT_FIRST_W-1:0] wake_ref_r;
    logic [7:0] rdata_nxt;
    logic hit_nxt;

    // two-flop sampling of both ports, idle high at reset so no false edge follows
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_meta_r <= '1;
            first_sync_r <= '1;
            second_meta_r <= '1;
            second_sync_r <= '1;
        end else begin
            first_meta_r <= first_port_lines_in;
            first_sync_r <= first_meta_r;
            second_meta_r <= second_port_lines_in;
            second_sync_r <= second_meta_r;
        end
    end

    // ****************************************
    // address decode
    // ****************************************
    // one-hot select for a port register
    function automatic logic sel(input logic [7:0] a, input logic [7:0] target);
        sel = (a == target);
    endfunction : sel

    // read mux: pad for input bits, latch for output bits
    function automatic logic [7:0] mix(input logic [7:0] dir, input logic [7:0] pad,
                                       input logic [7:0] lat);
        mix = (dir & pad) | (~dir & lat);
    endfunction : mix

    // ****************************************
    // data latches and direction registers
    // ****************************************
    // data latches hold until written
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_data_r <= BPT_DATA_RESET[BPT_FIRST_W-1:0];
            second_data_r <= BPT_DATA_RESET[BPT_SECOND_W-1:0];
        end else if (mem_wr_in) begin
            if (sel(mem_addr_in, BPT_FIRST_DATA_ADDR)) begin // [RULE1] [RULE3] [RULE9]
                first_data_r <= mem_wdata_in[BPT_FIRST_W-1:0];
            end
            if (sel(mem_addr_in, BPT_SECOND_DATA_ADDR)) begin // [RULE1] [RULE3] [RULE9]
                second_data_r <= mem_wdata_in[BPT_SECOND_W-1:0];
            end
        end
    end

    // direction registers, all inputs at reset
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_dir_r <= BPT_DIR_RESET[BPT_FIRST_W-1:0]; // [RULE8] [RULE16]
            second_dir_r <= BPT_DIR_RESET[BPT_SECOND_W-1:0]; // [RULE8] [RULE16]
        end else if (mem_wr_in) begin
            if (sel(mem_addr_in, BPT_FIRST_DIR_ADDR)) begin // [RULE4]
                first_dir_r <= mem_wdata_in[BPT_FIRST_W-1:0];
            end
            if (sel(mem_addr_in, BPT_SECOND_DIR_ADDR)) begin // [RULE4]
                second_dir_r <= mem_wdata_in[BPT_SECOND_W-1:0];
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // read value selection, unmapped gives zero and no hit
    always_comb begin
        rdata_nxt = 8'h00;
        hit_nxt = 1'b1;
        case (mem_addr_in)
            BPT_FIRST_DATA_ADDR: begin // [RULE2] [RULE5] [RULE6]
                rdata_nxt = mix(first_dir_r, first_sync_r, first_data_r);
            end
            BPT_FIRST_DIR_ADDR: begin
                rdata_nxt = first_dir_r;
            end
            BPT_SECOND_DATA_ADDR: begin
                rdata_nxt = mix({4'h0, second_dir_r}, {4'h0, second_sync_r},
                                {4'h0, second_data_r}); // [RULE5] [RULE6]
            end
            BPT_SECOND_DIR_ADDR: begin
                rdata_nxt = {4'h0, second_dir_r};
            end
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem_rdata_out <= 8'h00;
            mem_hit_out <= 1'b0;
        end else begin
            mem_hit_out <= mem_rd_in & hit_nxt;
            if (mem_rd_in) begin
                mem_rdata_out <= rdata_nxt; // [RULE2]
            end
        end
    end

    // ****************************************
    // pad drivers
    // ****************************************
    logic tone_both_out;
    logic tone_gated;
    assign tone_both_out = tone_opt_in & ~first_dir_r[BPT_TONE_BIT] & ~first_dir_r[BPT_TONE_N_BIT];
    assign tone_gated = first_data_r[BPT_TONE_BIT] & tone_in;

    // push-pull enables follow direction bits
    assign first_port_lines_oe_out = ~first_dir_r; // [RULE7] [RULE13]
    assign second_port_lines_oe_out = ~second_dir_r; // [RULE7]

    // line 0 and line 1 may carry the tone pair
    genvar gi;
    generate
        for (gi = 0; gi < BPT_FIRST_W; gi++) begin : g_first_drv
            if (gi == BPT_TONE_BIT) begin : g_tone
                assign first_port_lines_out[gi] = tone_opt_in ? tone_gated
                                                              : first_data_r[gi]; // [RULE14]
            end else if (gi == BPT_TONE_N_BIT) begin : g_tone_n
                assign first_port_lines_out[gi] = tone_both_out
                    ? (first_data_r[BPT_TONE_BIT] & ~tone_in)
                    : first_data_r[gi]; // [RULE15]
            end else begin : g_plain
                assign first_port_lines_out[gi] = first_data_r[gi];
            end
        end
    endgenerate
    assign second_port_lines_out = second_data_r;

    // pull-high attached only on input lines with the option
    assign first_pull_high_en_out = first_pull_high_opt_in & first_dir_r; // [RULE11]
    assign second_pull_high_en_out = second_pull_high_opt_in & second_dir_r; // [RULE11]

    // ****************************************
    // shared functions and wake-up
    // ****************************************
    // counter and interrupt pins see the synchronised pad
    assign counter0_ext_input_out = first_sync_r[BPT_CNT0_BIT]; // [RULE12]
    assign counter1_ext_input_out = first_sync_r[BPT_CNT1_BIT]; // [RULE12]
    assign ext_int_n_out = first_sync_r[BPT_EXTINT_BIT]; // [RULE12]

    // reference level for change detection while halted
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_ref_r <= '1;
        end else begin
            wake_ref_r <= first_sync_r;
        end
    end

    // any enabled line changing while halted wakes the device
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_out <= 1'b0;
        end else begin
            wake_out <= halted_in & |(wake_opt_in & (first_sync_r ^ wake_ref_r)); // [RULE10]
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    // a level change on an enabled first-port line while halted
    sequence s_wake_cause;
        halted_in && (|(wake_opt_in & (first_sync_r ^ wake_ref_r)));
    endsequence

    // a read of the second port data location
    sequence s_second_read;
        mem_rd_in && (mem_addr_in == BPT_SECOND_DATA_ADDR);
    endsequence

    a_out_enable_dir: assert property (@(posedge clock_in) // [RULE7]
        disable iff (!nrst_in) first_port_lines_oe_out == ~first_dir_r)
        else $error("first port enables do not follow direction");

    a_data_write_holds: assert property (@(posedge clock_in) // [RULE3]
        disable iff (!nrst_in) mem_wr_in && mem_addr_in == BPT_FIRST_DATA_ADDR
        |=> first_data_r == $past(mem_wdata_in))
        else $error("first data latch missed write");

    a_data_stable: assert property (@(posedge clock_in) // [RULE3]
        disable iff (!nrst_in)
        !(mem_wr_in && (mem_addr_in == BPT_FIRST_DATA_ADDR)) |=> $stable(first_data_r))
        else $error("first data latch changed without write");

    a_dir_write: assert property (@(posedge clock_in) // [RULE4]
        disable iff (!nrst_in) mem_wr_in && mem_addr_in == BPT_SECOND_DIR_ADDR
        |=> second_dir_r == $past(mem_wdata_in[BPT_SECOND_W-1:0]))
        else $error("second direction missed write");

    a_first_dir_write: assert property (@(posedge clock_in) // [RULE4]
        disable iff (!nrst_in) mem_wr_in && mem_addr_in == BPT_FIRST_DIR_ADDR
        |=> first_dir_r == $past(mem_wdata_in))
        else $error("first direction missed write");

    a_read_input_pad: assert property (@(posedge clock_in) // [RULE5] [RULE6]
        disable iff (!nrst_in) mem_rd_in && mem_addr_in == BPT_FIRST_DATA_ADDR
        |=> mem_hit_out && mem_rdata_out == (($past(first_dir_r) & $past(first_sync_r))
            | (~$past(first_dir_r) & $past(first_data_r))))
        else $error("first port read value wrong");

    a_second_read_mix: assert property (@(posedge clock_in) // [RULE5] [RULE6]
        disable iff (!nrst_in) s_second_read
        |=> mem_hit_out && mem_rdata_out == {4'h0, ($past(second_dir_r) & $past(second_sync_r))
            | (~$past(second_dir_r) & $past(second_data_r))})
        else $error("second port read value wrong");

    a_unmapped_miss: assert property (@(posedge clock_in) // [RULE1]
        disable iff (!nrst_in)
        mem_rd_in && (mem_addr_in < BPT_FIRST_DATA_ADDR || mem_addr_in > BPT_SECOND_DIR_ADDR)
        |=> !mem_hit_out && mem_rdata_out == 8'h00)
        else $error("unmapped read answered");

    a_pull_not_driven: assert property (@(posedge clock_in) // [RULE11]
        disable iff (!nrst_in)
        ((first_pull_high_en_out & first_port_lines_oe_out) == '0)
        && ((second_pull_high_en_out & second_port_lines_oe_out) == '0))
        else $error("pull-high attached to a driven line");

    a_tone_input_kept: assert property (@(posedge clock_in) // [RULE13]
        disable iff (!nrst_in) first_dir_r[BPT_TONE_BIT] |-> !first_port_lines_oe_out[BPT_TONE_BIT])
        else $error("tone line driven while input");

    a_tone_gate_low: assert property (@(posedge clock_in) // [RULE14]
        disable iff (!nrst_in)
        tone_opt_in && !first_data_r[BPT_TONE_BIT] |-> !first_port_lines_out[BPT_TONE_BIT])
        else $error("tone line not low with data zero");

    a_tone_inverted: assert property (@(posedge clock_in) // [RULE15]
        disable iff (!nrst_in) tone_both_out && first_data_r[BPT_TONE_BIT]
        |-> first_port_lines_out[BPT_TONE_N_BIT] == ~first_port_lines_out[BPT_TONE_BIT])
        else $error("line one not inverted tone");

    a_line_one_plain: assert property (@(posedge clock_in) // [RULE15]
        disable iff (!nrst_in)
        !tone_both_out |-> first_port_lines_out[BPT_TONE_N_BIT] == first_data_r[BPT_TONE_N_BIT])
        else $error("line one not its own data");

    a_wake_change: assert property (@(posedge clock_in) // [RULE10]
        disable iff (!nrst_in)
        halted_in && (wake_opt_in[0] && first_sync_r[0] != wake_ref_r[0]) |=> wake_out)
        else $error("wake not raised on line change");

    a_wake_any_line: assert property (@(posedge clock_in) // [RULE10]
        disable iff (!nrst_in) s_wake_cause |=> wake_out)
        else $error("wake not raised on enabled line");

    a_wake_idle: assert property (@(posedge clock_in) // [RULE10]
        disable iff (!nrst_in) !halted_in |=> !wake_out)
        else $error("wake raised while running");
endmodule : bpt_port

// File: verif/bpt_pad_model.sv
`timescale 1ns/100ps
module bpt_pad_model #(
    parameter int W = 8
) (
    input wire logic clock_in,
    input wire logic [W-1:0] drive_in,
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] pull_en_in,
    input wire logic [W-1:0] ext_en_in,
    input wire logic [W-1:0] ext_val_in,
    output logic [W-1:0] pad_out
);
    // ****************************************
    // pad resolution
    // ****************************************
    logic [W-1:0] float_r = '0;
    // undriven, unpulled pads wander every cycle
    always @(posedge clock_in) begin
        float_r <= ~float_r;
    end
    // device push-pull first, then outside driver, then pull-high
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_in[i]) pad_out[i] = drive_in[i];
            else if (ext_en_in[i]) pad_out[i] = ext_val_in[i];
            else if (pull_en_in[i]) pad_out[i] = 1'b1;
            else pad_out[i] = float_r[i];
        end
    end
endmodule : bpt_pad_model

// File: verif/bidir_port_with_tone_mux_test.sv
`timescale 1ns/100ps
module bidir_port_with_tone_mux_test;
    // ****************************************
    // signals
    // ****************************************
    logic clock_in, nrst, rd, wr, hit, halted, wake, tone_opt, tone, c0, c1, eint;
    logic [7:0] addr, wdata, rdata, pa, a_out, a_oe, a_pu, wake_opt, ext_a, pu_opt, ext_en_a;
    logic [3:0] pb, b_out, b_oe, b_pu, ext_b;
    int mismatches = 0;
    int check_count = 0;
    bpt_port dut_u (.clock_in(clock_in), .nrst_in(nrst), .mem_addr_in(addr), .mem_rd_in(rd),
        .mem_wr_in(wr), .mem_wdata_in(wdata), .mem_rdata_out(rdata), .mem_hit_out(hit),
        .first_port_lines_in(pa), .first_port_lines_out(a_out), .first_port_lines_oe_out(a_oe),
        .second_port_lines_in(pb), .second_port_lines_out(b_out),
        .second_port_lines_oe_out(b_oe), .first_pull_high_opt_in(pu_opt),
        .second_pull_high_opt_in(4'hf), .first_pull_high_en_out(a_pu),
        .second_pull_high_en_out(b_pu), .wake_opt_in(wake_opt), .halted_in(halted),
        .wake_out(wake), .tone_opt_in(tone_opt), .tone_in(tone),
        .counter0_ext_input_out(c0), .counter1_ext_input_out(c1), .ext_int_n_out(eint));
    bpt_pad_model #(.W(8)) pad_a_u (.clock_in(clock_in), .drive_in(a_out), .oe_in(a_oe),
        .pull_en_in(a_pu), .ext_en_in(ext_en_a), .ext_val_in(ext_a), .pad_out(pa));
    bpt_pad_model #(.W(4)) pad_b_u (.clock_in(clock_in), .drive_in(b_out), .oe_in(b_oe),
        .pull_en_in(b_pu), .ext_en_in(4'hf), .ext_val_in(ext_b), .pad_out(pb));
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in) #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clock_in) #1;
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
        @(posedge clock_in) #1;
        addr = a;
        rd = 1'b1;
        @(posedge clock_in) #1;
        rd = 1'b0;
        check("read data", exp, rdata);
        check("hit", {7'h00, exp_hit}, {7'h00, hit});
    endtask : rd_reg
    // change the outside level, then count wake pulses
    task automatic wake_count(input logic [7:0] v, input logic [7:0] exp);
        int n = 0;
        @(posedge clock_in) #1;
        ext_a = v;
        repeat (6) begin
            @(posedge clock_in) #1;
            if (wake === 1'b1) n++;
        end
        check("wake pulses", exp, 8'(n));
    endtask : wake_count
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        #80000;
        mismatches++;
        stop_test();
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        {nrst, rd, wr, halted, tone_opt, tone} = 6'h00;
        {addr, wdata, wake_opt, ext_a, ext_b} = {32'h0000_7f_a5, 4'h9};
        {pu_opt, ext_en_a} = 16'h7f_ff;
        repeat (6) @(posedge clock_in);
        #1 nrst = 1'b1;
        check("first oe", 8'h00, a_oe);
        check("second oe", 8'h00, {4'h0, b_oe});
        check("pull enable", 8'h7f, a_pu);
        rd_reg(8'h13, 8'hff, 1'b1);
        rd_reg(8'h15, 8'h0f, 1'b1);
        rd_reg(8'h12, 8'ha5, 1'b1);
        rd_reg(8'h14, 8'h09, 1'b1);
        $display("test reset and inputs done");
        wr_reg(8'h13, 8'h00);
        wr_reg(8'h12, 8'h3c);
        wr_reg(8'h15, 8'h0a);
        wr_reg(8'h14, 8'h0f);
        check("first oe", 8'hff, a_oe);
        check("first out", 8'h3c, a_out);
        check("second oe", 8'h05, {4'h0, b_oe});
        check("second out", 8'h0f, {4'h0, b_out});
        check("pull on outputs", 8'h00, a_pu);
        check("second pull", 8'h0a, {4'h0, b_pu});
        rd_reg(8'h12, 8'h3c, 1'b1);
        rd_reg(8'h14, 8'h0d, 1'b1);
        $display("test outputs done");
        wr_reg(8'h13, 8'hf0);
        repeat (3) @(posedge clock_in);
        rd_reg(8'h12, 8'hac, 1'b1);
        wr_reg(8'h12, 8'had);
        check("low latch", 8'h0d, a_out & 8'h0f);
        rd_reg(8'h16, 8'h00, 1'b0);
        wr_reg(8'h11, 8'hff);
        wr_reg(8'h13, 8'h00);
        check("latch kept", 8'had, a_out);
        $display("test read modify write done");
        tone_opt = 1'b1;
        wr_reg(8'h13, 8'hfc);
        wr_reg(8'h12, 8'h01);
        for (int t = 0; t < 2; t++) begin
            @(posedge clock_in) #1;
            tone = t[0];
            #1 check("tone pair", {6'h00, ~t[0], t[0]}, a_out & 8'h03);
        end
        wr_reg(8'h12, 8'h00);
        check("gated tone", 8'h00, a_out & 8'h03);
        wr_reg(8'h12, 8'h01);
        wr_reg(8'h13, 8'hfe);
        check("line one input", 8'h01, a_oe & 8'h03);
        check("tone alone", {7'h00, tone}, a_out & 8'h01);
        wr_reg(8'h13, 8'hfd);
        wr_reg(8'h12, 8'h02);
        check("own data", 8'h02, a_out & 8'h02);
        rd_reg(8'h12, 8'ha7, 1'b1);
        $display("test tone done");
        wr_reg(8'h13, 8'hff);
        ext_a = 8'h70;
        repeat (4) @(posedge clock_in);
        #1 check("shared inputs", 8'h07, {5'h00, eint, c1, c0});
        halted = 1'b1;
        wake_count(8'h74, 8'h01);
        wake_count(8'hf4, 8'h00);
        halted = 1'b0;
        wake_count(8'h70, 8'h00);
        {ext_en_a, pu_opt} = 16'h7f_ff;
        repeat (3) @(posedge clock_in);
        #1 check("pull enable", 8'hff, a_pu);
        rd_reg(8'h12, 8'hf0, 1'b1);
        $display("test shared pins and wake done");
        stop_test();
    end
endmodule : bidir_port_with_tone_mux_test
